// ===== dv/dwb_properties.sv
`timescale 1ns/1ps
module dwb_properties (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // link signals
  input wire dwb_pkg::dwb_cmd_t cmd,
  input wire logic [1:0] bank,
  input wire logic [5:0] col,
  input wire logic a10,
  input wire logic a12,
  input wire dwb_pkg::dwb_mr_t mr,
  input wire logic [15:0] dq,
  input wire logic [1:0] dm_n,
  input wire logic dqs
);
  dwb_pkg::dwb_mr_t mr_reg; // mode now in force
  logic is_wr; // write command this cycle
  logic is_mrs; // mode command this cycle
  logic wl9; // write latency of nine
  logic chop; // this write is a burst chop
  assign is_wr = cmd == dwb_pkg::CMD_WR;
  assign is_mrs = cmd == dwb_pkg::CMD_MRS;
  assign wl9 = mr_reg.cwl == 5'h09 && mr_reg.al == 4'h0 && !mr_reg.par;
  assign chop = mr_reg.bl == 2'h2 || (mr_reg.bl == 2'h1 && !a12);
  // track the mode the far end last took
  always_ff @(posedge CLK_I) begin
    if (SRST_I) mr_reg <= 16'h4800;
    else if (is_mrs) mr_reg <= mr;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wr_latency_a: assert property (is_wr && wl9 |-> ##8 !dqs ##1 dqs)
    else $error("write data not at write latency");
  slot_len_a: assert property ($rose(dqs) |-> dqs [*8] ##1 !dqs)
    else $error("strobe slot not eight beats");
  burst_quiet_a: assert property (dqs |-> !is_wr && !is_mrs)
    else $error("command during burst");
  chop_tail_a: assert property (is_wr && wl9 && chop |-> ##13 (dq == 16'h0 && dm_n == 2'h0) [*4])
    else $error("chop tail not blank");
  mode_legal_a: assert property (is_mrs |-> !(mr.pre2 && mr.cwl == 5'h09) && !(mr.dm && mr.dbi))
    else $error("illegal mode sent");
  pre2_gap_a: assert property (is_wr && mr_reg.pre2 |-> ##5 !is_wr)
    else $error("writes five apart");
  addr_hold_a: assert property (is_wr ##1 cmd == dwb_pkg::CMD_NOP |-> $stable({bank, col, a10, a12}))
    else $error("address not held");
  recovery_a: assert property ($fell(dqs) |-> !is_wr)
    else $error("write inside recovery");
endmodule : dwb_properties

// ===== dv/sdram_write_burst_path_tb_top.sv
`timescale 1ns/1ps
module sdram_write_burst_path_tb_top;
  // ------------------------------
  // bench signals
  // ------------------------------
  logic CLK_I = 1'b0; // 50 mhz clock
  logic SRST_I = 1'b1; // sync reset
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb request
  logic [7:0] paddr = 8'h00; // apb address
  logic [31:0] pwdata = 32'h0, prdata, rv; // apb data and read value
  logic pready, pslverr, se; // apb answer
  logic [7:0] rd_addr = 8'h00; // array readback address
  logic [15:0] rd_data; // array readback word
  logic [3:0] bank_open; // open banks
  logic crc_en, crc_persist, wr_done, err; // device status
  int n_errors = 0, checked = 0; // tallies
  logic [1:0] bl_c [4] = '{2'h0, 2'h1, 2'h1, 2'h2}; // burst codes
  logic a12_c [4] = '{1'b0, 1'b1, 1'b0, 1'b1}; // a12 choices
  int nb_c [4] = '{8, 8, 4, 4}; // beats stored per mode
  dwb_if i_dwb_if ();
  dwb_ctl i_dwb_ctl (.CLK_I(CLK_I), .SRST_I(SRST_I), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK(i_dwb_if.ctl));
  dwb_dev i_dwb_dev (.CLK_I(CLK_I), .SRST_I(SRST_I), .LINK(i_dwb_if.dev), .RD_ADDR_I(rd_addr),
    .RD_DATA_O(rd_data), .BANK_OPEN_O(bank_open), .CRC_EN_O(crc_en),
    .CRC_PERSIST_O(crc_persist), .WR_DONE_O(wr_done), .ERR_O(err));
  dwb_properties i_dwb_properties (.CLK_I(CLK_I), .SRST_I(SRST_I), .cmd(i_dwb_if.cmd),
    .bank(i_dwb_if.bank), .col(i_dwb_if.col), .a10(i_dwb_if.a10), .a12(i_dwb_if.a12),
    .mr(i_dwb_if.mr), .dq(i_dwb_if.dq), .dm_n(i_dwb_if.dm_n), .dqs(i_dwb_if.dqs));
  // free running clock
  initial begin
    forever #10 CLK_I = ~CLK_I;
  end
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // a wait that ran out
  task automatic stop(input string s);
    n_errors++;
    $display("[FAIL] %s expected 1 seen timeout", s);
    end_of_test();
  endtask : stop
  // one compare
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge CLK_I);
    penable <= 1'b1;
    do begin
      @(posedge CLK_I);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) stop("pready");
    @(posedge CLK_I);
  endtask : apb
  // push beats, issue the command, wait for the burst to end
  task automatic burst(input int nb, input logic [15:0] b, input int mb, input logic [31:0] c);
    int n;
    for (int k = 0; k < nb; k++) apb(1'b1, 8'h08, {14'h0, k == mb ? 2'h2 : 2'h3, b | 16'(k)});
    apb(1'b1, 8'h04, c);
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (wr_done !== 1'b1 && n < 100);
    if (wr_done !== 1'b1) stop("wr_done");
  endtask : burst
  // read one array word, one cycle of latency
  task automatic peek(input logic [7:0] a, input logic [15:0] e);
    rd_addr <= a;
    repeat (2) @(posedge CLK_I);
    chk("array word", {16'h0, e}, {16'h0, rd_data});
  endtask : peek
  // main sequence
  initial begin
    repeat (2) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {16'h0, 16'h4804 | 16'(bl_c[i])});
      apb(1'b1, 8'h04, 32'h400 | i);
      burst(nb_c[i], 16'(16'h1100 * (i + 1)), 8, {22'h0, a12_c[i], 9'h0} | i);
      for (int k = 0; k < nb_c[i]; k++) peek(8'(i * 64 + k), 16'(16'h1100 * (i + 1) + k));
    end
    chk("open banks", 32'hf, {28'h0, bank_open});
    burst(4, 16'hc0c0, 2, 32'h100);
    chk("open banks", 32'he, {28'h0, bank_open});
    for (int k = 0; k < 8; k++) peek(8'(k), k == 2 ? 16'hc002 : 16'(k < 4 ? 16'hc0c0 + k : 16'h1100 + k));
    apb(1'b1, 8'h00, 32'h4824);
    apb(1'b0, 8'h0c, 32'h0);
    chk("cfg_err", 32'h2, rv & 32'h2);
    // two-clock preamble with write latency ten is legal
    apb(1'b1, 8'h00, 32'h5024);
    burst(8, 16'h5500, 8, 32'h41);
    peek(8'h50, 16'h5500);
    apb(1'b1, 8'h00, 32'h4814);
    repeat (3) @(posedge CLK_I);
    chk("crc persist", 32'h1, {31'h0, crc_persist});
    chk("crc enable", 32'h1, {31'h0, crc_en});
    apb(1'b1, 8'h00, 32'h4810);
    repeat (3) @(posedge CLK_I);
    chk("crc persist", 32'h0, {31'h0, crc_persist});
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", 32'h1, {31'h0, se});
    chk("err flag", 32'h0, {31'h0, err});
    end_of_test();
  end
endmodule : sdram_write_burst_path_tb_top

// ===== hw/dwb_ctl.sv
`timescale 1ns/1ps

module dwb_ctl (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // link to the memory
  dwb_if.ctl LINK
);
  localparam int twr_cyc = `DWB_TWR_CYC;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    dwb_pkg::dwb_cst_t st;  // sequencer
    dwb_pkg::dwb_mr_t cfg;  // mode shadow
    logic cfg_err;          // last mode write refused
    logic mrs_pend;         // mode command to send
    logic pend;             // staged command
    logic p_act;            // staged command is activate
    logic [1:0] p_bank;     // staged bank
    logic [5:0] p_col;      // staged column
    logic p_a10;            // staged auto precharge
    logic p_a12;            // staged burst select
    logic [5:0] cnt;        // latency or recovery count
    logic [2:0] beat;       // beat driven in the data state
    logic bc4;              // burst is chopped
    logic [2:0] gap;        // edges since last write
    logic pready;           // bus answer
    logic pslverr;          // bus error
    logic [31:0] prdata;    // read data
    dwb_pkg::dwb_cmd_t cmd; // link command
    logic [1:0] bank;
    logic [5:0] col;
    logic a10;
    logic a12;
    dwb_pkg::dwb_mr_t mr;
    logic [15:0] dq;
    logic [1:0] dm_n;
    logic dqs;
  } dwb_ctl_st_t;

  dwb_ctl_st_t s_reg;
  dwb_ctl_st_t s_next;
  logic acc;                             // access phase
  logic commit;                          // bus write or read completes
  logic push;                            // data word into fifo
  logic pop;                             // beat taken from fifo
  logic fin_rdy;                         // fifo has room
  logic [`DWB_FIFO_W-1:0] fout;          // fifo head
  logic [4:0] lvl;                       // fifo level
  logic [4:0] need;                      // beats a staged write needs
  logic [4:0] need_b;                    // beats the running burst uses
  logic [2:0] bidx;                      // beat driven now
  logic drive;                           // a beat is driven now
  dwb_pkg::dwb_mr_t mr_w;                // mode value written

  // ----------------------------------------
  // write data buffer
  // ----------------------------------------
  dwb_fifo #(.W(`DWB_FIFO_W), .D(`DWB_FIFO_D)) u_fifo (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .in_valid_i(push),
    .in_ready_o(fin_rdy),
    .in_data_i(PWDATA_I[`DWB_FIFO_W-1:0]),
    .out_valid_o(),
    .out_ready_i(pop),
    .out_data_o(fout),
    .level_o(lvl)
  );

  // ----------------------------------------
  // bus decode and sequencer
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.cmd = dwb_pkg::CMD_NOP;
    s_next.dqs = 1'b0;
    mr_w = PWDATA_I[15:0];
    acc = PSEL_I && PENABLE_I;
    commit = acc && s_reg.pready;
    push = commit && PWRITE_I && (PADDR_I == `DWB_OFF_DATA);
    need = dwb_pkg::dwb_is_bc4(s_reg.cfg.bl, s_reg.p_a12) ? `DWB_BEATS_BC4 : `DWB_BEATS_BL8;
    need_b = s_reg.bc4 ? `DWB_BEATS_BC4 : `DWB_BEATS_BL8;
    drive = ((s_reg.st == dwb_pkg::C_WAIT) && (s_reg.cnt == 6'h00)) ||
            (s_reg.st == dwb_pkg::C_DATA);
    bidx = (s_reg.st == dwb_pkg::C_DATA) ? s_reg.beat : 3'h0;
    pop = drive && ({2'h0, bidx} < need_b);
    if (s_reg.gap != `DWB_GAP_RST) begin
      s_next.gap = s_reg.gap + 3'h1;
    end
    // answer one cycle into the access, stall while full or staged
    if (acc && !s_reg.pready) begin
      s_next.prdata = 32'h0;
      case (PADDR_I)
        `DWB_OFF_CFG: begin
          s_next.pready = 1'b1;
          s_next.prdata = {16'h0, s_reg.cfg};
        end
        `DWB_OFF_CMD: begin
          s_next.pready = !(PWRITE_I && s_reg.pend);
          s_next.prdata = {21'h0, s_reg.p_act, s_reg.p_a12, s_reg.p_a10,
                           s_reg.p_col, s_reg.p_bank};
        end
        `DWB_OFF_DATA: begin
          s_next.pready = !PWRITE_I || fin_rdy;
        end
        `DWB_OFF_STAT: begin
          s_next.pready = 1'b1;
          s_next.prdata = {23'h0, lvl, s_reg.mrs_pend, s_reg.pend, s_reg.cfg_err,
                           (s_reg.st != dwb_pkg::C_IDLE)};
        end
        default: begin
          s_next.pready = 1'b1;
          s_next.pslverr = 1'b1;
        end
      endcase
    end
    // writes take effect at the completing edge
    if (commit && PWRITE_I) begin
      case (PADDR_I)
        `DWB_OFF_CFG: begin
          if ((mr_w.pre2 && (mr_w.cwl == `DWB_CWL_MIN)) || (mr_w.dm && mr_w.dbi)) begin
            s_next.cfg_err = 1'b1;  // RULE_13 RULE_07
          end else begin
            s_next.cfg = mr_w;
            s_next.mrs_pend = 1'b1;
            s_next.cfg_err = 1'b0;
          end
        end
        `DWB_OFF_CMD: begin
          s_next.pend = 1'b1;
          {s_next.p_act, s_next.p_a12, s_next.p_a10, s_next.p_col, s_next.p_bank} =
            PWDATA_I[10:0];
        end
        default: begin
        end
      endcase
    end
    case (s_reg.st)
      // issue mode, activate, or a write once its data is buffered
      dwb_pkg::C_IDLE: begin
        if (s_reg.mrs_pend) begin
          s_next.cmd = dwb_pkg::CMD_MRS;
          s_next.mr = s_reg.cfg;
          s_next.mrs_pend = 1'b0;
        end else if (s_reg.pend && s_reg.p_act) begin
          s_next.cmd = dwb_pkg::CMD_ACT;
          s_next.bank = s_reg.p_bank;
          s_next.pend = 1'b0;
        end else if (s_reg.pend && (lvl >= need) &&
                     !(s_reg.cfg.pre2 && (s_reg.gap == `DWB_GAP_BAD_PRE2))) begin  // RULE_14
          s_next.cmd = dwb_pkg::CMD_WR;
          s_next.bank = s_reg.p_bank;
          s_next.col = s_reg.p_col;
          s_next.a10 = s_reg.p_a10;
          s_next.a12 = s_reg.p_a12;  // RULE_02
          s_next.pend = 1'b0;
          s_next.bc4 = dwb_pkg::dwb_is_bc4(s_reg.cfg.bl, s_reg.p_a12);
          s_next.cnt = dwb_pkg::dwb_wl(s_reg.cfg) - 6'h01;  // RULE_17
          s_next.gap = 3'h1;
          s_next.st = dwb_pkg::C_WAIT;
        end
      end
      dwb_pkg::C_WAIT: begin
        if (s_reg.cnt == 6'h00) begin
          s_next.st = dwb_pkg::C_DATA;
          s_next.beat = 3'h1;
        end else begin
          s_next.cnt = s_reg.cnt - 6'h01;
        end
      end
      dwb_pkg::C_DATA: begin
        if (s_reg.beat == `DWB_LAST_BEAT) begin
          s_next.st = dwb_pkg::C_TAIL;
        end else begin
          s_next.beat = s_reg.beat + 3'h1;
        end
      end
      // the next edge is the one after the last beat
      dwb_pkg::C_TAIL: begin
        s_next.st = dwb_pkg::C_REC;
        s_next.cnt = 6'(twr_cyc - 1);  // RULE_15
      end
      dwb_pkg::C_REC: begin
        if (s_reg.cnt == 6'h00) begin
          s_next.st = dwb_pkg::C_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 6'h01;
        end
      end
      default: begin
        s_next.st = dwb_pkg::C_IDLE;
      end
    endcase
    // each beat held the full cycle up to its sample edge
    if (drive) begin
      s_next.dqs = 1'b1;  // RULE_16
      s_next.dq = pop ? fout[15:0] : 16'h0;
      s_next.dm_n = pop ? fout[17:16] : 2'h0;  // RULE_18
    end
  end

  // state register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s_reg <= '0;
      s_reg.st <= dwb_pkg::C_IDLE;
      s_reg.cmd <= dwb_pkg::CMD_NOP;
      s_reg.cfg <= `DWB_MR_RST;
      s_reg.gap <= `DWB_GAP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PRDATA_O = s_reg.prdata;
  assign PREADY_O = s_reg.pready;
  assign PSLVERR_O = s_reg.pslverr;
  assign LINK.cmd = s_reg.cmd;
  assign LINK.bank = s_reg.bank;
  assign LINK.col = s_reg.col;
  assign LINK.a10 = s_reg.a10;
  assign LINK.a12 = s_reg.a12;
  assign LINK.mr = s_reg.mr;
  assign LINK.dq = s_reg.dq;
  assign LINK.dm_n = s_reg.dm_n;
  assign LINK.dqs = s_reg.dqs;
endmodule : dwb_ctl

// ===== hw/dwb_dev.sv
`timescale 1ns/1ps
// Function
// (RULE_01) writes take BL8, BC4 or on-the-fly bursts
// (RULE_02) on-the-fly: a12 low chop, high eight
// (RULE_03) a10 low: bank stays open after burst
// (RULE_04) a10 high: bank precharged after burst
// (RULE_05) masking only on x8 and x16 parts
// (RULE_06) lane pin function chosen by configuration
// (RULE_07) mask and inversion never both enabled
// (RULE_08) mask pin low: lane not stored
// (RULE_09) mask pin high: lane stored
// (RULE_10) crc persistent when mask enabled, else not
// (RULE_11) burst field 00 eight, 01 on-the-fly
// (RULE_12) burst field 10 forces four-beat chop
// (RULE_13) two-clock preamble forbids write latency nine
// (RULE_14) two-clock preamble forbids write spacing five
// (RULE_15) recovery counted from edge after last beat
// (RULE_16) untrained capture must meet worst-case limits
// (RULE_17) data starts additive+cas write+parity latency later
// (RULE_18) chopped burst stores only first four beats

module dwb_dev (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // link from the controller
  dwb_if.dev LINK,
  // array readback
  input wire logic [7:0] RD_ADDR_I,
  output logic [15:0] RD_DATA_O,
  // status
  output logic [3:0] BANK_OPEN_O,
  output logic CRC_EN_O,
  output logic CRC_PERSIST_O,
  output logic WR_DONE_O,
  output logic ERR_O
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    dwb_pkg::dwb_dst_t st;  // burst sequencer
    dwb_pkg::dwb_mr_t mr;   // mode register
    logic [5:0] cnt;        // latency countdown
    logic [2:0] beat;       // beat index sampled in the data state
    logic [1:0] bank;       // burst bank
    logic [2:0] col;        // burst column group
    logic a10;              // auto precharge pending
    logic bc4;              // chopped burst
    logic [3:0] bank_act;   // open banks
    logic done;             // burst end pulse
    logic err;              // sticky protocol error
    logic crc_p;            // crc persistent mode
    logic [15:0] rd;        // readback word
  } dwb_dev_st_t;

  dwb_dev_st_t s_reg;
  dwb_dev_st_t s_next;
  logic samp;               // a beat is sampled at this edge
  logic [2:0] bidx;         // index of that beat
  logic store;              // beat goes to the array
  logic dm_act;             // pins act as mask
  logic dbi_act;            // pins act as inversion
  logic [7:0] widx;         // array write index
  wire [1:0] we;            // lane write enables
  wire [15:0] wd;           // lane write data
  wire [15:0] rdw;          // array read data

  // ----------------------------------------
  // beat capture decode
  // ----------------------------------------
  always_comb begin
    samp = ((s_reg.st == dwb_pkg::D_WAIT) && (s_reg.cnt == 6'h00)) ||
           (s_reg.st == dwb_pkg::D_DATA);  // RULE_17
    bidx = (s_reg.st == dwb_pkg::D_DATA) ? s_reg.beat : 3'h0;
    store = samp && LINK.dqs && !(s_reg.bc4 && bidx[2]);  // RULE_18
    // pin function from mode: mask, inversion, or neither
    dm_act = s_reg.mr.dm && !s_reg.mr.dbi && (`DWB_ORG_BITS != 4);  // RULE_05 RULE_06 RULE_07
    dbi_act = s_reg.mr.dbi && !s_reg.mr.dm;  // RULE_06 RULE_07
    widx = {s_reg.bank, s_reg.col, bidx};
  end

  // ----------------------------------------
  // per-lane storage
  // ----------------------------------------
  for (genvar g = 0; g < `DWB_LANES; g++) begin : g_lane
    logic [7:0] mem [`DWB_MEM_DEPTH];  // lane array
    // masked lane is dropped, unmasked lane is written
    assign we[g] = store && !(dm_act && !LINK.dm_n[g]);  // RULE_08 RULE_09
    // inversion flag low means the lane arrived inverted
    assign wd[8*g +: 8] = (dbi_act && !LINK.dm_n[g]) ? ~LINK.dq[8*g +: 8] :
                          LINK.dq[8*g +: 8];  // RULE_06
    assign rdw[8*g +: 8] = mem[RD_ADDR_I];

    // lane array write
    always_ff @(posedge CLK_I) begin
      if (we[g]) begin
        mem[widx] <= wd[8*g +: 8];
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.rd = rdw;
    s_next.crc_p = s_reg.mr.crc && s_reg.mr.dm;  // RULE_10
    // activate may land in any state
    if (LINK.cmd == dwb_pkg::CMD_ACT) begin
      s_next.bank_act[LINK.bank] = 1'b1;
    end
    case (s_reg.st)
      // wait for a command
      dwb_pkg::D_IDLE: begin
        if (LINK.cmd == dwb_pkg::CMD_MRS) begin
          s_next.mr = LINK.mr;
        end else if (LINK.cmd == dwb_pkg::CMD_WR) begin
          if (!s_reg.bank_act[LINK.bank]) begin
            s_next.err = 1'b1;
          end
          s_next.st = dwb_pkg::D_WAIT;
          s_next.cnt = dwb_pkg::dwb_wl(s_reg.mr) - 6'h01;  // RULE_17
          s_next.bank = LINK.bank;
          s_next.col = LINK.col[5:3];
          s_next.a10 = LINK.a10;
          // burst field and a12 pick eight or four beats
          s_next.bc4 = dwb_pkg::dwb_is_bc4(s_reg.mr.bl, LINK.a12);  // RULE_01 RULE_02 RULE_11 RULE_12
        end
      end
      // count the write latency, first beat when it runs out
      dwb_pkg::D_WAIT: begin
        if (s_reg.cnt == 6'h00) begin
          s_next.st = dwb_pkg::D_DATA;
          s_next.beat = 3'h1;
        end else begin
          s_next.cnt = s_reg.cnt - 6'h01;
        end
      end
      // remaining beats of the eight-beat slot
      dwb_pkg::D_DATA: begin
        if (s_reg.beat == `DWB_LAST_BEAT) begin
          s_next.st = dwb_pkg::D_IDLE;
          s_next.done = 1'b1;  // RULE_15
          if (s_reg.a10) begin
            s_next.bank_act[s_reg.bank] = 1'b0;  // RULE_04
          end else begin
            s_next.bank_act[s_reg.bank] = 1'b1;  // RULE_03
          end
        end else begin
          s_next.beat = s_reg.beat + 3'h1;
        end
      end
      default: begin
        s_next.st = dwb_pkg::D_IDLE;
      end
    endcase
    // commands other than activate are not taken mid-burst
    if ((s_reg.st != dwb_pkg::D_IDLE) &&
        ((LINK.cmd == dwb_pkg::CMD_WR) || (LINK.cmd == dwb_pkg::CMD_MRS))) begin
      s_next.err = 1'b1;
    end
  end

  // state register
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s_reg <= '0;
      s_reg.st <= dwb_pkg::D_IDLE;
      s_reg.mr <= `DWB_MR_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign RD_DATA_O = s_reg.rd;
  assign BANK_OPEN_O = s_reg.bank_act;
  assign CRC_EN_O = s_reg.mr.crc;
  assign CRC_PERSIST_O = s_reg.crc_p;
  assign WR_DONE_O = s_reg.done;
  assign ERR_O = s_reg.err;
endmodule : dwb_dev

// ===== hw/dwb_fifo.sv
`timescale 1ns/1ps

module dwb_fifo #(
  parameter int W = 18,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  // fill level
  output logic [$clog2(D):0] level_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;  // write pointer
    logic [AW-1:0] rp;  // read pointer
    logic [AW:0] cnt;   // words held
  } dwb_fifo_st_t;

  dwb_fifo_st_t s_reg;
  dwb_fifo_st_t s_next;
  logic [W-1:0] mem [D];  // storage
  logic push;
  logic pop;

  // ----------------------------------------
  // handshakes
  // ----------------------------------------
  assign in_ready_o = (s_reg.cnt != (AW+1)'(D));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o = mem[s_reg.rp];
  assign level_o = s_reg.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // next pointers and count
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[s_reg.wp] <= in_data_i;
    end
  end
endmodule : dwb_fifo

// ===== hw/dwb_if.sv
`timescale 1ns/1ps

// ----------------------------------------
// command, mode and write data link
// ----------------------------------------
interface dwb_if;
  dwb_pkg::dwb_cmd_t cmd;  // command this cycle
  logic [1:0] bank;        // bank address
  logic [5:0] col;         // column address
  logic a10;               // auto precharge
  logic a12;               // on-the-fly burst select
  dwb_pkg::dwb_mr_t mr;    // mode value with mode command
  logic [15:0] dq;         // write data beat
  logic [1:0] dm_n;        // shared mask or inversion pin per lane
  logic dqs;               // beat strobe

  modport dev (input cmd, bank, col, a10, a12, mr, dq, dm_n, dqs);
  modport ctl (output cmd, bank, col, a10, a12, mr, dq, dm_n, dqs);
endinterface : dwb_if

// ===== hw/dwb_params.svh
`ifndef DWB_PARAMS_SVH
`define DWB_PARAMS_SVH

// ----------------------------------------
// link widths and organisation
// ----------------------------------------
`define DWB_DQ_W 16
`define DWB_LANES 2
`define DWB_ORG_BITS 16
`define DWB_MEM_DEPTH 256

// ----------------------------------------
// burst field codes and beat counts
// ----------------------------------------
`define DWB_BL_FIX8 2'h0
`define DWB_BL_OTF 2'h1
`define DWB_BL_FIX4 2'h2
`define DWB_BEATS_BL8 5'h08
`define DWB_BEATS_BC4 5'h04
`define DWB_LAST_BEAT 3'h7

// ----------------------------------------
// mode register reset value and latency figures
// ----------------------------------------
`define DWB_MR_RST 16'h4800
`define DWB_PL 6'h04
`define DWB_CWL_MIN 5'h09
`define DWB_GAP_BAD_PRE2 3'h5
`define DWB_GAP_RST 3'h7

// ----------------------------------------
// write recovery time
// ----------------------------------------
`define DWB_CLK_MHZ 50
`define DWB_TWR_NS 15
`define DWB_TWR_CYC (((`DWB_TWR_NS * `DWB_CLK_MHZ) + 999) / 1000)

// ----------------------------------------
// controller register offsets
// ----------------------------------------
`define DWB_OFF_CFG 8'h00
`define DWB_OFF_CMD 8'h04
`define DWB_OFF_DATA 8'h08
`define DWB_OFF_STAT 8'h0c

// ----------------------------------------
// fifo shape
// ----------------------------------------
`define DWB_FIFO_W 18
`define DWB_FIFO_D 16

`endif

// ===== hw/dwb_pkg.sv
`include "dwb_params.svh"

package dwb_pkg;

  // ----------------------------------------
  // link commands and mode register layout
  // ----------------------------------------
  typedef enum logic [1:0] {CMD_NOP, CMD_MRS, CMD_ACT, CMD_WR} dwb_cmd_t;

  typedef struct packed {
    logic [4:0] cwl;  // cas write latency
    logic [3:0] al;   // additive latency
    logic par;        // command parity enable
    logic pre2;       // two-clock write preamble
    logic crc;        // write crc enable
    logic dbi;        // data bus inversion enable
    logic dm;         // data mask enable
    logic [1:0] bl;   // burst field
  } dwb_mr_t;

  // ----------------------------------------
  // state machines
  // ----------------------------------------
  typedef enum logic [1:0] {D_IDLE, D_WAIT, D_DATA} dwb_dst_t;
  typedef enum logic [2:0] {C_IDLE, C_WAIT, C_DATA, C_TAIL, C_REC} dwb_cst_t;

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  // burst chop decision from burst field and a12
  function automatic logic dwb_is_bc4(input logic [1:0] bl, input logic a12);
    case (bl)
      `DWB_BL_OTF: return !a12;
      `DWB_BL_FIX4: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : dwb_is_bc4

  // write latency in clocks
  function automatic logic [5:0] dwb_wl(input dwb_mr_t mr);
    return {1'b0, mr.cwl} + {2'h0, mr.al} + (mr.par ? `DWB_PL : 6'h00);
  endfunction : dwb_wl

endpackage : dwb_pkg
